// file: verilog/abrs_top.sv
/*
 AXI4 / AXI4-Lite slave front end to a flip-flop block RAM with separate
 write and read engines. Assumes an AXI master or interconnect on the same
 clock that has already removed any system base address.
*/
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Top
// ****************************************************************
module abrs_top
   import abrs_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int DEPTH = 1024,
   parameter int ID_W = 4,
   parameter logic [1:0] MODE = ABRS_MODE_MEM,
   parameter bit USE_IMAGE = 1'b0,
   parameter logic [DATA_W-1:0] INIT_DEFAULT = '0,
   parameter logic [DEPTH*DATA_W-1:0] INIT_COEFFICIENT_IMAGE = '0
) (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [ID_W-1:0] i_awid,
   input wire logic [ABRS_BUS_ADDR_W-1:0] i_awaddr,
   input wire logic [7:0] i_awlen,
   input wire logic [2:0] i_awsize,
   input wire logic [1:0] i_awburst,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic [DATA_W/8-1:0] i_wstrb,
   input wire logic i_wlast,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [ID_W-1:0] o_bid,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ID_W-1:0] i_arid,
   input wire logic [ABRS_BUS_ADDR_W-1:0] i_araddr,
   input wire logic [7:0] i_arlen,
   input wire logic [2:0] i_arsize,
   input wire logic [1:0] i_arburst,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [ID_W-1:0] o_rid,
   output logic [DATA_W-1:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rlast,
   output logic o_rvalid,
   input wire logic i_rready
);
   localparam int BYTES = DATA_W / 8;
   localparam int LSB = $clog2(BYTES);
   localparam int IDX_W = $clog2(DEPTH);
   localparam int ADDR_W = IDX_W + LSB;
   localparam bit IS_LITE = (MODE == ABRS_MODE_LITE_MEM) || (MODE == ABRS_MODE_LITE_PERIPH);
   // Full memory mode alone decodes byte lanes
   localparam bit NARROW_OK = (MODE == ABRS_MODE_MEM);
   localparam logic [5:0] W_SET = (MODE == ABRS_MODE_MEM) ? ABRS_W_MEM :
                                  (MODE == ABRS_MODE_LITE_MEM) ? ABRS_W_LITE_MEM :
                                  (MODE == ABRS_MODE_PERIPH) ? ABRS_W_PERIPH :
                                  ABRS_W_LITE_PERIPH;
   localparam bit IS_MEM = (MODE == ABRS_MODE_MEM) || (MODE == ABRS_MODE_LITE_MEM);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // Width per mode one width on bus and RAM, no converter
   if ((DATA_W < 8) || (DATA_W > 256) || ((1 << LSB) * 8 != DATA_W) || !W_SET[LSB]) begin : g_bad_w
      $error("abrs_top: bad data width");
   end
   // Depth a power of two; memory modes cover 4 kB, peripheral two words
   if (((1 << IDX_W) != DEPTH) || (DEPTH < ABRS_PERIPH_MIN_DEPTH) ||
       (IS_MEM && (DEPTH * BYTES < ABRS_MEM_MIN_BYTES)) || (ADDR_W > ABRS_BUS_ADDR_W)) begin : g_bad_d
      $error("abrs_top: bad depth");
   end

   // ****************************************************************
   // Address helpers
   // ****************************************************************
   // Next beat address: FIXED holds, INCR steps, WRAP folds in the line
   function automatic logic [ADDR_W-1:0] f_next(input logic [ADDR_W-1:0] a,
         input logic [2:0] size, logic [7:0] len, logic [1:0] burst);
      logic [31:0] step;
      logic [31:0] incr;
      logic [31:0] wmask;
      step = 32'h1 << size;
      incr = (32'(a) & ~(step - 32'h1)) + step;
      wmask = ((32'(len) + 32'h1) << size) - 32'h1;
      case (burst)
         ABRS_BURST_FIXED: f_next = a;
         ABRS_BURST_WRAP: f_next = ADDR_W'((32'(a) & ~wmask) | (incr & wmask));
         default: f_next = ADDR_W'(incr);
      endcase
   endfunction : f_next

   // Live lanes of a beat: start offset to end of size window
   function automatic logic [BYTES-1:0] f_lanes(input logic [ADDR_W-1:0] a,
         logic [2:0] size);
      logic [31:0] off;
      logic [31:0] top;
      f_lanes = '0;
      off = 32'(a) % 32'(BYTES);
      top = (off & ~((32'h1 << size) - 32'h1)) + (32'h1 << size);
      for (int i = 0; i < BYTES; i++) begin
         f_lanes[i] = (32'(i) >= off) && (32'(i) < top);
      end
   endfunction : f_lanes

   // Local byte address: high bits ignored base is zero
   function automatic logic [ADDR_W-1:0] f_local(input logic [ABRS_BUS_ADDR_W-1:0] a);
      logic [ADDR_W-1:0] low;
      low = a[ADDR_W-1:0];
      // Byte-within-word bits read as zero outside full memory mode
      f_local = NARROW_OK ? low : (low & ~ADDR_W'(BYTES - 1));
   endfunction : f_local

   // ****************************************************************
   // Write engine
   // ****************************************************************
   abrs_wstate_t wst_ff;
   logic [ADDR_W-1:0] waddr_ff;
   logic [7:0] wlen_ff;
   logic [7:0] wcnt_ff;
   logic [2:0] wsize_ff;
   logic [1:0] wburst_ff;
   logic aw_fire;
   logic w_fire;
   logic w_last_beat;
   logic [BYTES-1:0] wr_be;

   assign aw_fire = i_awvalid && o_awready;
   assign w_fire = i_wvalid && o_wready;
   // Length field, not the master's last flag, ends the burst
   assign w_last_beat = (wcnt_ff == wlen_ff);
   // Strobes drive byte enables, clipped to the live lanes
   assign wr_be = w_fire ? (i_wstrb & f_lanes(waddr_ff, wsize_ff)) : '0;

   // Write state and handshake flags
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wst_ff <= ABRS_W_IDLE;
         o_awready <= ABRS_READY_RST;
         o_wready <= ABRS_READY_RST;
         o_bvalid <= ABRS_VALID_RST;
      end else begin
         case (wst_ff)
            ABRS_W_IDLE: begin
               o_awready <= !aw_fire;
               if (aw_fire) begin
                  wst_ff <= ABRS_W_DATA;
                  o_wready <= 1'b1;
               end
            end
            ABRS_W_DATA: begin
               if (w_fire && w_last_beat) begin
                  // One response after the last beat lands in the RAM
                  wst_ff <= ABRS_W_RESP;
                  o_wready <= 1'b0;
                  o_bvalid <= 1'b1;
               end
            end
            ABRS_W_RESP: begin
               // A stalled response stalls the next burst
               if (i_bready) begin
                  wst_ff <= ABRS_W_IDLE;
                  o_bvalid <= 1'b0;
                  o_awready <= 1'b1;
               end
            end
            default: begin
               wst_ff <= ABRS_W_IDLE;
               o_awready <= 1'b0;
               o_wready <= 1'b0;
               o_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // Burst bookkeeping for writes
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         waddr_ff <= '0;
         wlen_ff <= '0;
         wcnt_ff <= '0;
         wsize_ff <= '0;
         wburst_ff <= ABRS_BURST_INCR;
         o_bid <= '0;
         o_bresp <= ABRS_RESP_OKAY;
      end else if (aw_fire) begin
         // Unaligned start kept as given in full memory mode; lite is single full beats
         waddr_ff <= f_local(i_awaddr);
         wlen_ff <= IS_LITE ? 8'h0 : i_awlen;
         wsize_ff <= NARROW_OK ? i_awsize : 3'(LSB);
         wburst_ff <= IS_LITE ? ABRS_BURST_INCR : i_awburst;
         wcnt_ff <= '0;
         o_bid <= i_awid;
         o_bresp <= ABRS_RESP_OKAY;
      end else if (w_fire) begin
         // Word index changes only when the step crosses a word boundary
         waddr_ff <= f_next(waddr_ff, wsize_ff, wlen_ff, wburst_ff);
         wcnt_ff <= wcnt_ff + 8'h1;
      end
   end

   // ****************************************************************
   // Read engine
   // ****************************************************************
   abrs_rstate_t rst_ff;
   logic [ADDR_W-1:0] raddr_ff;
   logic [7:0] rlen_ff;
   logic [7:0] rcnt_ff;
   logic [2:0] rsize_ff;
   logic [1:0] rburst_ff;
   logic rdone_ff;
   logic ar_fire;
   logic r_load;
   logic [DATA_W-1:0] rd_word;
   logic [DATA_W-1:0] rd_mask;
   logic [BYTES-1:0] rd_lanes;

   assign ar_fire = i_arvalid && o_arready;
   // Output slot frees when empty or taken; throttling holds it
   assign r_load = (rst_ff == ABRS_R_DATA) && (!o_rvalid || i_rready);

   // Byte mask from the live lanes of this beat
   assign rd_lanes = f_lanes(raddr_ff, rsize_ff);
   for (genvar b = 0; b < BYTES; b++) begin : g_rmask
      assign rd_mask[b*8+:8] = {8{rd_lanes[b]}};
   end

   // Read state and handshake flags
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_ff <= ABRS_R_IDLE;
         o_arready <= ABRS_READY_RST;
         o_rvalid <= ABRS_VALID_RST;
         o_rlast <= 1'b0;
      end else begin
         case (rst_ff)
            ABRS_R_IDLE: begin
               o_arready <= !ar_fire;
               if (ar_fire) begin
                  rst_ff <= ABRS_R_DATA;
               end
            end
            ABRS_R_DATA: begin
               if (r_load) begin
                  if (rdone_ff) begin
                     rst_ff <= ABRS_R_IDLE;
                     o_rvalid <= 1'b0;
                     o_rlast <= 1'b0;
                     o_arready <= 1'b1;
                  end else begin
                     // Last beat set by the length field
                     o_rvalid <= 1'b1;
                     o_rlast <= (rcnt_ff == rlen_ff);
                  end
               end
            end
            default: begin
               rst_ff <= ABRS_R_IDLE;
               o_arready <= 1'b0;
               o_rvalid <= 1'b0;
               o_rlast <= 1'b0;
            end
         endcase
      end
   end

   // Burst bookkeeping and read data
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         raddr_ff <= '0;
         rlen_ff <= '0;
         rcnt_ff <= '0;
         rsize_ff <= '0;
         rburst_ff <= ABRS_BURST_INCR;
         rdone_ff <= 1'b0;
         o_rid <= '0;
         o_rdata <= '0;
         o_rresp <= ABRS_RESP_OKAY;
      end else if (ar_fire) begin
         raddr_ff <= f_local(i_araddr);
         rlen_ff <= IS_LITE ? 8'h0 : i_arlen;
         rsize_ff <= NARROW_OK ? i_arsize : 3'(LSB);
         rburst_ff <= IS_LITE ? ABRS_BURST_INCR : i_arburst;
         rcnt_ff <= '0;
         rdone_ff <= 1'b0;
         o_rid <= i_arid;
         o_rresp <= ABRS_RESP_OKAY;
      end else if (r_load && !rdone_ff) begin
         // RAM word, masked to the live lanes, to the output flop
         o_rdata <= rd_word & rd_mask;
         raddr_ff <= f_next(raddr_ff, rsize_ff, rlen_ff, rburst_ff);
         rcnt_ff <= rcnt_ff + 8'h1;
         rdone_ff <= (rcnt_ff == rlen_ff);
      end
   end

   // ****************************************************************
   // RAM
   // ****************************************************************
   // Word index drops the byte-lane bits of the local address
   abrs_ram #(
      .DATA_W(DATA_W),
      .DEPTH(DEPTH),
      .IDX_W(IDX_W),
      .USE_IMAGE(USE_IMAGE),
      .INIT_DEFAULT(INIT_DEFAULT),
      .INIT_COEFFICIENT_IMAGE(INIT_COEFFICIENT_IMAGE)
   ) u_ram (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_wr_idx(waddr_ff[ADDR_W-1:LSB]),
      .i_wr_be(wr_be),
      .i_wr_data(i_wdata),
      .i_rd_idx(raddr_ff[ADDR_W-1:LSB]),
      .o_rd_data(rd_word)
   );
endmodule : abrs_top

`default_nettype wire

// file: verilog/abrs_pkg.sv
/*
 Constants shared by the AXI4 block RAM slave: operating modes, burst
 and response codes, and the address range and depth limits.
 Assumes nothing beyond a SystemVerilog compiler.
*/
// Functional notes
// - Bursts starting at a byte address not word aligned complete correctly.
// - Widths 32-256 memory, 32/64 lite memory; peripheral adds 8, 16, depth 2.
// - Memory modes decode at least a 4 kB byte range, fixing minimum depth.
// - Peripheral modes impose no address bit minimum; depth down to two.
// - Peripheral and lite memory modes treat byte-within-word address bits as zero.
// - Full memory mode decodes low address bits and supports narrow transfers.
// - Bus address is a 32-bit byte address.
// - RAM word address is the byte address with byte-lane bits dropped.
// - Local address range always begins at zero.
// - Address bits above the configured range are ignored.
// - Bus data width equals RAM data width, one-to-one.
// - No registered RAM output stage; read data from RAM read path.
// - No extra pipeline stages on the RAM output path.
// - Contents start from a per-location image or one default value.
// - Incrementing bursts of 1 to 256 beats end by the length field.
// - Wrapping bursts of 2, 4, 8, 16 wrap to the aligned line start.
// - Narrow writes use strobes as byte enables; word address advances on boundary.

// ****************************************************************
// Package
// ****************************************************************
package abrs_pkg;
   // Operating modes
   localparam logic [1:0] ABRS_MODE_MEM = 2'h0;
   localparam logic [1:0] ABRS_MODE_LITE_MEM = 2'h1;
   localparam logic [1:0] ABRS_MODE_PERIPH = 2'h2;
   localparam logic [1:0] ABRS_MODE_LITE_PERIPH = 2'h3;
   // Burst and response codes
   localparam logic [1:0] ABRS_BURST_FIXED = 2'h0;
   localparam logic [1:0] ABRS_BURST_INCR = 2'h1;
   localparam logic [1:0] ABRS_BURST_WRAP = 2'h2;
   localparam logic [1:0] ABRS_RESP_OKAY = 2'h0;
   // Address and depth limits
   localparam int ABRS_BUS_ADDR_W = 32;
   localparam int ABRS_MEM_MIN_BYTES = 4096;
   localparam int ABRS_PERIPH_MIN_DEPTH = 2;
   // Reset values of handshake outputs
   localparam logic ABRS_READY_RST = 1'b0;
   localparam logic ABRS_VALID_RST = 1'b0;
   // Legal widths per mode, one bit per power of two from 8 to 256
   localparam logic [5:0] ABRS_W_MEM = 6'h3c;
   localparam logic [5:0] ABRS_W_LITE_MEM = 6'h0c;
   localparam logic [5:0] ABRS_W_PERIPH = 6'h3f;
   localparam logic [5:0] ABRS_W_LITE_PERIPH = 6'h0f;

   typedef enum logic [1:0] {ABRS_W_IDLE, ABRS_W_DATA, ABRS_W_RESP} abrs_wstate_t;
   typedef enum logic [1:0] {ABRS_R_IDLE, ABRS_R_DATA} abrs_rstate_t;
endpackage : abrs_pkg

// file: verilog/abrs_ram.sv
/*
 Flip-flop RAM with a byte-enabled write port and an unregistered read
 port. Assumes one clock and an asynchronous active low reset that loads
 the initial contents.
*/
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// RAM array
// ****************************************************************
module abrs_ram
   import abrs_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int DEPTH = 1024,
   parameter int IDX_W = 10,
   parameter bit USE_IMAGE = 1'b0,
   parameter logic [DATA_W-1:0] INIT_DEFAULT = '0,
   parameter logic [DEPTH*DATA_W-1:0] INIT_COEFFICIENT_IMAGE = '0
) (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [IDX_W-1:0] i_wr_idx,
   input wire logic [DATA_W/8-1:0] i_wr_be,
   input wire logic [DATA_W-1:0] i_wr_data,
   input wire logic [IDX_W-1:0] i_rd_idx,
   output logic [DATA_W-1:0] o_rd_data
);
   logic [DATA_W-1:0] mem_ff [DEPTH];

   // One process per word and byte lane
   for (genvar g = 0; g < DEPTH; g++) begin : g_word
      for (genvar b = 0; b < DATA_W / 8; b++) begin : g_lane
         always_ff @(posedge i_sys_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               // Image per location, else one default for all
               mem_ff[g][b*8+:8] <= USE_IMAGE ? INIT_COEFFICIENT_IMAGE[g*DATA_W+b*8+:8]
                                              : INIT_DEFAULT[b*8+:8];
            end else if (i_wr_be[b] && (i_wr_idx == IDX_W'(g))) begin
               mem_ff[g][b*8+:8] <= i_wr_data[b*8+:8];
            end
         end
      end
   end

   // Plain read path, no output stage
   assign o_rd_data = mem_ff[i_rd_idx];
endmodule : abrs_ram

`default_nettype wire

// file: testbench/abrs_top_chk.sv
/*
 Checker for the AXI block RAM slave handshakes, bound to abrs_top.
 Assumes one clock and an asynchronous active low reset.
*/
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Checker
// ****************************************************************
module abrs_top_chk
   import abrs_pkg::*;
#(
   parameter int DATA_W = 32
) (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [7:0] i_awlen,
   input wire logic [1:0] i_awburst,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_arlen,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic o_rlast,
   input wire logic o_rvalid,
   input wire logic i_rready
);
   logic [7:0] wlen_ff, wcnt_ff, rlen_ff, rcnt_ff;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   // Own beat counts, independent of the design
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wlen_ff <= 8'h0;
         wcnt_ff <= 8'h0;
      end else if (i_awvalid && o_awready) begin
         wlen_ff <= i_awlen;
         wcnt_ff <= 8'h0;
      end else if (i_wvalid && o_wready) begin
         wcnt_ff <= wcnt_ff + 8'h1;
      end
   end

   // Read beat count
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rlen_ff <= 8'h0;
         rcnt_ff <= 8'h0;
      end else if (i_arvalid && o_arready) begin
         rlen_ff <= i_arlen;
         rcnt_ff <= 8'h0;
      end else if (o_rvalid && i_rready) begin
         rcnt_ff <= rcnt_ff + 8'h1;
      end
   end

   AST_WR_OPEN: assert property ((i_awvalid && o_awready) |=> o_wready && !o_awready)
      else $error("no data phase");
   AST_B_LAST: assert property ((i_wvalid && o_wready && wcnt_ff == wlen_ff) |=>
      o_bvalid && !o_wready)
      else $error("late response");
   AST_B_OKAY: assert property (o_bvalid |-> o_bresp == ABRS_RESP_OKAY)
      else $error("bad write response");
   AST_B_ONE: assert property ((o_bvalid && i_bready) |=> !o_bvalid && o_awready)
      else $error("response not closed");
   AST_RD_LAT: assert property ((i_arvalid && o_arready) |=> !o_rvalid ##1 o_rvalid)
      else $error("read latency wrong");
   AST_R_HOLD: assert property ((o_rvalid && !i_rready) |=>
      o_rvalid && $stable(o_rdata) && $stable(o_rlast))
      else $error("stalled beat changed");
   AST_RLAST: assert property (o_rvalid |-> o_rlast == (rcnt_ff == rlen_ff))
      else $error("bad last flag");
   AST_R_END: assert property ((o_rvalid && i_rready && o_rlast) |=> !o_rvalid && o_arready)
      else $error("read burst not closed");

   // Main scenarios reached
   cover property (i_awvalid && o_awready && i_awburst == ABRS_BURST_WRAP);
   cover property (o_rvalid && !i_rready);
   cover property (o_bvalid && !i_bready);
endmodule : abrs_top_chk

bind abrs_top abrs_top_chk #(.DATA_W(DATA_W)) i_abrs_top_chk (
   .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_awlen(i_awlen), .i_awburst(i_awburst),
   .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
   .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arlen(i_arlen),
   .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rlast(o_rlast),
   .o_rvalid(o_rvalid), .i_rready(i_rready));

`default_nettype wire

// file: testbench/abrs_master.sv
/*
 AXI master model driving the block RAM slave for the bench.
 Assumes wr and rd are called one at a time.
*/
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Master model
// ****************************************************************
module abrs_master (
   input wire logic i_sys_clk,
   output logic [31:0] o_awaddr,
   output logic [7:0] o_awlen,
   output logic [2:0] o_awsize,
   output logic [1:0] o_awburst,
   output logic o_awvalid,
   input wire logic i_awready,
   output logic [31:0] o_wdata,
   output logic [3:0] o_wstrb,
   output logic o_wlast,
   output logic o_wvalid,
   input wire logic i_wready,
   input wire logic i_bvalid,
   input wire logic [1:0] i_bresp,
   output logic o_bready,
   output logic [31:0] o_araddr,
   output logic [7:0] o_arlen,
   output logic [2:0] o_arsize,
   output logic [1:0] o_arburst,
   output logic o_arvalid,
   input wire logic i_arready,
   input wire logic [31:0] i_rdata,
   input wire logic i_rvalid,
   output logic o_rready
);
   // Idle bus from time zero
   initial begin
      {o_awaddr, o_awlen, o_awsize, o_awburst, o_awvalid} = '0;
      {o_wdata, o_wstrb, o_wlast, o_wvalid, o_bready} = '0;
      {o_araddr, o_arlen, o_arsize, o_arburst, o_arvalid, o_rready} = '0;
   end

   // Write burst; released lines show inverted values
   task automatic wr(input logic [31:0] a, logic [7:0] len, logic [2:0] sz, logic [1:0] bt,
                     logic [31:0] d[$], logic [3:0] s[$], bit slow, output logic [1:0] resp);
      @(posedge i_sys_clk);
      o_awaddr <= a;
      o_awlen <= len;
      o_awsize <= sz;
      o_awburst <= bt;
      o_awvalid <= 1'b1;
      do @(posedge i_sys_clk); while (!i_awready);
      o_awvalid <= 1'b0;
      o_awaddr <= ~a;
      for (int n = 0; n <= len; n++) begin
         o_wdata <= d[n];
         o_wstrb <= s[n];
         o_wlast <= (n == len);
         o_wvalid <= 1'b1;
         do @(posedge i_sys_clk); while (!i_wready);
      end
      o_wvalid <= 1'b0;
      o_wlast <= 1'b0;
      o_wdata <= ~d[len];
      // A stall costs RAM write slots
      if (slow) repeat (3) @(posedge i_sys_clk);
      o_bready <= 1'b1;
      do @(posedge i_sys_clk); while (!i_bvalid);
      resp = i_bresp;
      o_bready <= 1'b0;
   endtask : wr

   // Read burst; slow toggles ready
   task automatic rd(input logic [31:0] a, logic [7:0] len, logic [2:0] sz, logic [1:0] bt,
                     bit slow, output logic [31:0] q[$]);
      q = {};
      @(posedge i_sys_clk);
      o_araddr <= a;
      o_arlen <= len;
      o_arsize <= sz;
      o_arburst <= bt;
      o_arvalid <= 1'b1;
      do @(posedge i_sys_clk); while (!i_arready);
      o_arvalid <= 1'b0;
      o_araddr <= ~a;
      o_rready <= !slow;
      while (q.size() <= len) begin
         @(posedge i_sys_clk);
         if (i_rvalid && o_rready) q.push_back(i_rdata);
         if (q.size() <= len) o_rready <= slow ? !o_rready : 1'b1;
         else o_rready <= 1'b0;
      end
   endtask : rd
endmodule : abrs_master

`default_nettype wire

// file: testbench/abrs_top_test.sv
/*
 Self-checking bench for the AXI block RAM slave in full memory mode.
 Assumes the master model in abrs_master and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Bench
// ****************************************************************
module abrs_top_test;
   import abrs_pkg::*;
   // Default word; partial writes show
   localparam logic [31:0] DEF = 32'hc3c3_3c3c;
   logic i_sys_clk;
   logic i_nrst;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [7:0] awlen, arlen;
   logic [2:0] awsize, arsize;
   logic [1:0] awburst, arburst, bresp, resp, rresp;
   logic [3:0] bid, rid;
   logic [3:0] wstrb;
   logic awvalid, awready, wlast, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] d[$], q[$];
   logic [3:0] s[$];
   int fails, checks_done;

   // Equal widths on both sides of the RAM
   abrs_top #(.INIT_DEFAULT(DEF)) i_abrs_top (
      .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_awid(4'h3), .i_awaddr(awaddr),
      .i_awlen(awlen), .i_awsize(awsize), .i_awburst(awburst), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wlast(wlast),
      .i_wvalid(wvalid), .o_wready(wready), .o_bid(bid), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_arid(4'h5), .i_araddr(araddr), .i_arlen(arlen),
      .i_arsize(arsize), .i_arburst(arburst), .i_arvalid(arvalid), .o_arready(arready),
      .o_rid(rid), .o_rdata(rdata), .o_rresp(rresp), .o_rlast(), .o_rvalid(rvalid),
      .i_rready(rready));

   abrs_master i_abrs_master (
      .i_sys_clk(i_sys_clk), .o_awaddr(awaddr), .o_awlen(awlen), .o_awsize(awsize),
      .o_awburst(awburst), .o_awvalid(awvalid), .i_awready(awready), .o_wdata(wdata),
      .o_wstrb(wstrb), .o_wlast(wlast), .o_wvalid(wvalid), .i_wready(wready),
      .i_bvalid(bvalid), .i_bresp(bresp), .o_bready(bready), .o_araddr(araddr),
      .o_arlen(arlen), .o_arsize(arsize), .o_arburst(arburst), .o_arvalid(arvalid),
      .i_arready(arready), .i_rdata(rdata), .i_rvalid(rvalid), .o_rready(rready));

   // 250 MHz clock
   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end

   task automatic check(input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   // Write burst of d and s
   task automatic put(input logic [31:0] a, logic [7:0] len, logic [2:0] sz, logic [1:0] bt,
                      bit slow);
      i_abrs_master.wr(a, len, sz, bt, d, s, slow, resp);
      check({30'h0, resp}, {30'h0, ABRS_RESP_OKAY});
      check({28'h0, bid}, 32'h3);
   endtask : put

   task automatic get(input logic [31:0] a, logic [7:0] len, logic [2:0] sz, logic [1:0] bt,
                      bit slow);
      i_abrs_master.rd(a, len, sz, bt, slow, q);
      check({26'h0, rid, rresp}, {26'h0, 4'h5, ABRS_RESP_OKAY});
   endtask : get

   task automatic expect_q(input logic [31:0] e[$]);
      check(32'(q.size()), 32'(e.size()));
      foreach (e[n]) check(q[n], e[n]);
   endtask : expect_q

   task automatic t_default;
      get(32'h0000_0100, 8'h0, 3'h2, ABRS_BURST_INCR, 1'b0);
      expect_q('{DEF});
   endtask : t_default

   // Longest burst; high address bits ignored
   task automatic t_long;
      d = {};
      s = {};
      for (int n = 0; n < 256; n++) begin
         d.push_back(32'h5a00_0000 + 32'(n));
         s.push_back(4'hf);
      end
      put(32'ha000_1400, 8'hff, 3'h2, ABRS_BURST_INCR, 1'b1);
      get(32'h0000_0400, 8'hff, 3'h2, ABRS_BURST_INCR, 1'b1);
      expect_q(d);
   endtask : t_long

   task automatic t_unal;
      d = '{32'haabb_ccdd, 32'h1122_3344};
      s = '{4'hf, 4'hf};
      put(32'h0000_0022, 8'h1, 3'h2, ABRS_BURST_INCR, 1'b0);
      get(32'h0000_0020, 8'h1, 3'h2, ABRS_BURST_INCR, 1'b0);
      expect_q('{{16'haabb, DEF[15:0]}, 32'h1122_3344});
      get(32'h0000_0022, 8'h0, 3'h2, ABRS_BURST_INCR, 1'b0);
      expect_q('{32'haabb_0000});
   endtask : t_unal

   // Half-word beats share a word until the boundary is crossed
   task automatic t_narrow;
      d = '{32'h1234_a1a1, 32'hb2b2_5678, 32'h9abc_c3d3, 32'he4e4_def0};
      s = '{4'h3, 4'hc, 4'h3, 4'hc};
      put(32'h0000_0040, 8'h3, 3'h1, ABRS_BURST_INCR, 1'b0);
      get(32'h0000_0040, 8'h1, 3'h2, ABRS_BURST_INCR, 1'b0);
      expect_q('{32'hb2b2_a1a1, 32'he4e4_c3d3});
      get(32'h0000_0042, 8'h0, 3'h1, ABRS_BURST_INCR, 1'b0);
      expect_q('{32'hb2b2_0000});
   endtask : t_narrow

   task automatic t_wrap;
      d = '{32'h0e0e_0e00, 32'h0e0e_0e01, 32'h0e0e_0e02, 32'h0e0e_0e03};
      s = '{4'hf, 4'hf, 4'hf, 4'hf};
      put(32'h0000_0068, 8'h3, 3'h2, ABRS_BURST_WRAP, 1'b0);
      get(32'h0000_0060, 8'h3, 3'h2, ABRS_BURST_INCR, 1'b0);
      expect_q('{d[2], d[3], d[0], d[1]});
      get(32'h0000_0068, 8'h3, 3'h2, ABRS_BURST_WRAP, 1'b1);
      expect_q(d);
   endtask : t_wrap

   // Watchdog: run needs about 900 cycles
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      fails++;
      close_out();
   end

   initial begin
      i_nrst = 1'b0;
      repeat (6) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      t_default();
      t_long();
      t_unal();
      t_narrow();
      t_wrap();
      close_out();
   end
endmodule : abrs_top_test

`default_nettype wire
